// File: core/fbmb_mailbox.sv
// Notes on behaviour
// - General layout: slot byte 00 is command.
// - Command 201 sets window start from bytes 02-03.
// - Window is three registers; count byte ignored.
// - Returned byte 00 is ack or error code.
// - Returned byte 01 holds slave error code.
// - Returned bytes 02-07 hold weight.
// - Returned bytes 08-11 hold both status registers.
// - Bytes 12-19: window address, three read registers.
// - Slot n starts at byte 20*(n-1), sixteen slots.
// - Transmitter layout: command 10-11, setpoints 12-19.
// - Transmitter returns error, status, weights, setpoints.
// - Words integer then decimal, MSB at lower address.
// - Setpoints echoed back in bytes 12-19.
// - Words 1-6 switch relays on or off.
// - Words 7-12 tare, zero, mode, weight selection.
// - Words 13 and above do nothing.
// - Action only when the command word changes.
// - Write request carries at most eight registers.
// - Error 255 marks communication failure.
// - Command 202 clears power-fail bit 4, status 2.
//
// Strobed register access and the register offsets were chosen for this implementation.
`default_nettype none

module fbmb_mailbox (
	input wire logic clk,
	input wire logic srst,
	input wire logic [8:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_we,
	input wire logic bus_re,
	output logic [7:0] bus_rdata,
	input wire logic [15:0] slot_is_wei,
	input wire logic cmd_ready,
	output logic cmd_valid,
	output logic [3:0] cmd_slot,
	output logic [7:0] cmd_code,
	output logic [3:0] cmd_count,
	output logic [15:0] cmd_addr,
	output logic [127:0] cmd_data,
	output logic act_valid,
	output logic [3:0] act_slot,
	output fbmb_pkg::fbmb_act_t act_code,
	input wire logic rsp_valid,
	input wire logic [3:0] rsp_slot,
	input wire logic rsp_fail,
	input wire logic [7:0] rsp_ack,
	input wire logic [7:0] rsp_err,
	input wire logic [47:0] rsp_weight,
	input wire logic [15:0] rsp_stat1,
	input wire logic [15:0] rsp_stat2,
	input wire logic [47:0] rsp_regs,
	input wire logic [15:0] rsp_werr,
	input wire logic [15:0] rsp_wstat,
	input wire logic [31:0] rsp_gross,
	input wire logic [31:0] rsp_net
);

	// ************************************************************
	// State.
	// ************************************************************
	typedef struct packed {
		logic [319:0][7:0] rx;
		logic [319:0][7:0] tx;
		logic [15:0][15:0] last;
		logic [15:0][15:0] win;
		logic [3:0] scan;
		logic pend;
		logic [3:0] pend_slot;
		logic [7:0] pend_ack;
		logic [7:0] rdata;
		logic cmd_valid;
		logic [3:0] cmd_slot;
		logic [7:0] cmd_code;
		logic [3:0] cmd_count;
		logic [15:0] cmd_addr;
		logic [127:0] cmd_data;
		logic act_valid;
		logic [3:0] act_slot;
		fbmb_pkg::fbmb_act_t act_code;
	} fbmb_state_t;

	fbmb_state_t s_q;
	fbmb_state_t s_d;
	fbmb_pkg::fbmb_act_t dec_act;
	logic [15:0] scan_word;

	// Slot n occupies bytes 20*(n-1) onward; slot index here is n-1.
	function automatic logic [8:0] fbmb_at(input logic [3:0] slot, input logic [4:0] off);
		return 9'(slot) * fbmb_pkg::SLOT_STRIDE + 9'(off);
	endfunction : fbmb_at

	always_comb begin
		if (slot_is_wei[s_q.scan]) begin
			scan_word = {s_q.rx[fbmb_at(s_q.scan, fbmb_pkg::OFF_WCMD)],
				s_q.rx[fbmb_at(s_q.scan, fbmb_pkg::OFF_WCMD + 5'h01)]};
		end else begin
			scan_word = {8'h00, s_q.rx[fbmb_at(s_q.scan, fbmb_pkg::OFF_CMD)]};
		end
	end

	fbmb_wei_decode u_decode (
		.cmd_word(scan_word),
		.act(dec_act)
	);

	// ************************************************************
	// Next state.
	// ************************************************************
	always_comb begin
		logic go;
		logic [7:0] cnt;
		logic [8:0] b;
		go = 1'b0;
		cnt = 8'h00;
		b = 9'h000;
		s_d = s_q;
		s_d.cmd_valid = 1'b0;
		s_d.act_valid = 1'b0;
		s_d.rdata = 8'h00;

		// Master port: unmapped reads answer zero, unmapped writes vanish.
		if (bus_re && bus_addr < fbmb_pkg::MEM_BYTES) begin
			s_d.rdata = s_q.tx[bus_addr];
		end
		if (bus_we && bus_addr < fbmb_pkg::MEM_BYTES) begin
			s_d.rx[bus_addr] = bus_wdata;
		end

		// Acks of the general layout trail their data by one cycle so
		// that a master polling byte 00 never sees a stale payload.
		if (s_q.pend) begin
			s_d.tx[fbmb_at(s_q.pend_slot, fbmb_pkg::OFF_CMD)] = s_q.pend_ack;
			s_d.pend = 1'b0;
		end

		// Scanner visits one slot per cycle; a general slot waits for the
		// serial side to accept, so no command is dropped.
		b = fbmb_at(s_q.scan, 5'h00);
		go = slot_is_wei[s_q.scan] || cmd_ready;
		if (slot_is_wei[s_q.scan]) begin
			for (int k = 0; k < 8; k++) begin
				s_d.tx[b + 9'(fbmb_pkg::OFF_SP) + 9'(k)] =
					s_q.rx[b + 9'(fbmb_pkg::OFF_SP) + 9'(k)];
			end
		end
		if (go) begin
			s_d.scan = s_q.scan + 4'h1;
			if (scan_word != s_q.last[s_q.scan]) begin
				s_d.last[s_q.scan] = scan_word;
				if (slot_is_wei[s_q.scan]) begin
					s_d.act_valid = (dec_act != fbmb_pkg::act_none);
					s_d.act_slot = s_q.scan;
					s_d.act_code = dec_act;
				end else begin
					cnt = s_q.rx[b + 9'(fbmb_pkg::OFF_CNT)];
					s_d.cmd_valid = 1'b1;
					s_d.cmd_slot = s_q.scan;
					s_d.cmd_code = scan_word[7:0];
					s_d.cmd_addr = {s_q.rx[b + 9'(fbmb_pkg::OFF_ADR)],
						s_q.rx[b + 9'(fbmb_pkg::OFF_ADR) + 9'h001]};
					s_d.cmd_count = (cnt > fbmb_pkg::MAX_REGS) ? 4'h8 : cnt[3:0];
					for (int k = 0; k < 16; k++) begin
						s_d.cmd_data[127 - 8 * k -: 8] =
							s_q.rx[b + 9'(fbmb_pkg::OFF_WREG) + 9'(k)];
					end
					if (scan_word[7:0] == fbmb_pkg::CODE_WINDOW) begin
						s_d.cmd_count = fbmb_pkg::WINDOW_REGS;
						s_d.win[s_q.scan] = s_d.cmd_addr;
					end
				end
			end
		end

		// Answers from the serial side.
		if (rsp_valid) begin
			b = fbmb_at(rsp_slot, 5'h00);
			if (slot_is_wei[rsp_slot]) begin
				s_d.tx[b] = rsp_fail ? fbmb_pkg::ERR_COMM : rsp_werr[15:8];
				s_d.tx[b + 9'h001] = rsp_fail ? fbmb_pkg::ERR_COMM : rsp_werr[7:0];
				s_d.tx[b + 9'(fbmb_pkg::OFF_WSTAT)] = rsp_wstat[15:8];
				s_d.tx[b + 9'(fbmb_pkg::OFF_WSTAT) + 9'h001] = rsp_wstat[7:0];
				for (int k = 0; k < 4; k++) begin
					s_d.tx[b + 9'(fbmb_pkg::OFF_GROSS) + 9'(k)] = rsp_gross[31 - 8 * k -: 8];
					s_d.tx[b + 9'(fbmb_pkg::OFF_NET) + 9'(k)] = rsp_net[31 - 8 * k -: 8];
				end
			end else begin
				s_d.tx[b + 9'(fbmb_pkg::OFF_ERR)] = rsp_fail ? fbmb_pkg::ERR_COMM : rsp_err;
				for (int k = 0; k < 6; k++) begin
					s_d.tx[b + 9'(fbmb_pkg::OFF_WGT) + 9'(k)] = rsp_weight[47 - 8 * k -: 8];
					s_d.tx[b + 9'(fbmb_pkg::OFF_RREG) + 9'(k)] = rsp_regs[47 - 8 * k -: 8];
				end
				s_d.tx[b + 9'(fbmb_pkg::OFF_ST1)] = rsp_stat1[15:8];
				s_d.tx[b + 9'(fbmb_pkg::OFF_ST1) + 9'h001] = rsp_stat1[7:0];
				s_d.tx[b + 9'(fbmb_pkg::OFF_ST1) + 9'h002] = rsp_stat2[15:8];
				s_d.tx[b + 9'(fbmb_pkg::OFF_ST2_LO)] = rsp_stat2[7:0];
				if (!rsp_fail && rsp_ack == fbmb_pkg::CODE_PF_CLEAR) begin
					s_d.tx[b + 9'(fbmb_pkg::OFF_ST2_LO)][fbmb_pkg::PF_BIT] = 1'b0;
				end
				s_d.tx[b + 9'(fbmb_pkg::OFF_WIN)] = s_q.win[rsp_slot][15:8];
				s_d.tx[b + 9'(fbmb_pkg::OFF_WIN) + 9'h001] = s_q.win[rsp_slot][7:0];
				s_d.pend = 1'b1;
				s_d.pend_slot = rsp_slot;
				s_d.pend_ack = rsp_fail ? fbmb_pkg::ERR_COMM : rsp_ack;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign bus_rdata = s_q.rdata;
	assign cmd_valid = s_q.cmd_valid;
	assign cmd_slot = s_q.cmd_slot;
	assign cmd_code = s_q.cmd_code;
	assign cmd_count = s_q.cmd_count;
	assign cmd_addr = s_q.cmd_addr;
	assign cmd_data = s_q.cmd_data;
	assign act_valid = s_q.act_valid;
	assign act_slot = s_q.act_slot;
	assign act_code = s_q.act_code;

	// ************************************************************
	// Checks.
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence gen_answer;
		rsp_valid && !slot_is_wei[rsp_slot];
	endsequence

	sequence ack_pending;
		s_q.pend && s_q.pend_slot == $past(rsp_slot);
	endsequence

	sequence wei_answer;
		rsp_valid && slot_is_wei[rsp_slot];
	endsequence

	a_unmapped_read: assert property ((bus_re && bus_addr >= fbmb_pkg::MEM_BYTES) |=>
		bus_rdata == 8'h00)
		else $error("unmapped read did not return zero");
	a_write_cap: assert property (cmd_valid |-> cmd_count <= 4'h8)
		else $error("write count above eight");
	a_window_three: assert property ((cmd_valid && cmd_code == fbmb_pkg::CODE_WINDOW) |->
		cmd_count == fbmb_pkg::WINDOW_REGS)
		else $error("window count not three");
	a_window_start: assert property ((cmd_valid && cmd_code == fbmb_pkg::CODE_WINDOW) |->
		s_q.win[cmd_slot] == cmd_addr)
		else $error("window start not stored");
	a_ack_after_data: assert property (gen_answer |=> ack_pending ##1 !s_q.pend)
		else $error("ack not staged after data");
	a_ack_written: assert property (s_q.pend |=>
		s_q.tx[fbmb_at($past(s_q.pend_slot), fbmb_pkg::OFF_CMD)] == $past(s_q.pend_ack))
		else $error("ack byte not written");
	a_comm_fail: assert property ((rsp_valid && !slot_is_wei[rsp_slot] && rsp_fail) |=>
		s_q.pend_ack == fbmb_pkg::ERR_COMM)
		else $error("comm failure not coded 255");
	a_pf_clear: assert property ((rsp_valid && !slot_is_wei[rsp_slot] && !rsp_fail &&
		rsp_ack == fbmb_pkg::CODE_PF_CLEAR) |=>
		!s_q.tx[fbmb_at($past(rsp_slot), fbmb_pkg::OFF_ST2_LO)][fbmb_pkg::PF_BIT])
		else $error("power-fail bit not cleared");
	a_act_on_change: assert property (act_valid |-> $changed(s_q.last))
		else $error("action without command change");
	a_act_range: assert property (act_valid |->
		(s_q.last[act_slot] != 16'h0000 && s_q.last[act_slot] <= fbmb_pkg::WCMD_LAST))
		else $error("action for a no-action word");
	a_cmd_on_change: assert property (cmd_valid |-> $changed(s_q.last))
		else $error("command issued without change");
	a_layout_split: assert property (act_valid |-> slot_is_wei[act_slot])
		else $error("action raised for a general slot");
	a_cmd_general: assert property (cmd_valid |-> !slot_is_wei[cmd_slot])
		else $error("command raised for a transmitter slot");

	// Payload checks look at the first byte of the weight, status and gross fields and at the whole
	// window and transmitter error words, where a slipped slot base or a swapped byte order shows up first.
	a_gen_weight: assert property (gen_answer |=>
		s_q.tx[fbmb_at($past(rsp_slot), fbmb_pkg::OFF_WGT)] == $past(rsp_weight[47:40]))
		else $error("weight high byte misplaced");
	a_gen_window: assert property (gen_answer |=>
		{s_q.tx[fbmb_at($past(rsp_slot), fbmb_pkg::OFF_WIN)],
		s_q.tx[fbmb_at($past(rsp_slot), fbmb_pkg::OFF_WIN + 5'h01)]} ==
		$past(s_q.win[rsp_slot]))
		else $error("window start not returned");
	a_gen_status: assert property (gen_answer |=>
		s_q.tx[fbmb_at($past(rsp_slot), fbmb_pkg::OFF_ST1)] == $past(rsp_stat1[15:8]))
		else $error("status register misplaced");
	a_wei_error: assert property (wei_answer |=>
		{s_q.tx[fbmb_at($past(rsp_slot), fbmb_pkg::OFF_CMD)],
		s_q.tx[fbmb_at($past(rsp_slot), fbmb_pkg::OFF_CMD + 5'h01)]} ==
		($past(rsp_fail) ? 16'hFFFF : $past(rsp_werr)))
		else $error("transmitter error word misplaced");
	a_wei_gross: assert property (wei_answer |=>
		s_q.tx[fbmb_at($past(rsp_slot), fbmb_pkg::OFF_GROSS)] == $past(rsp_gross[31:24]))
		else $error("gross weight high byte misplaced");
	a_sp_echo: assert property (slot_is_wei[s_q.scan] |=>
		s_q.tx[fbmb_at($past(s_q.scan), fbmb_pkg::OFF_SP)] ==
		$past(s_q.rx[fbmb_at(s_q.scan, fbmb_pkg::OFF_SP)]))
		else $error("setpoint not echoed");

endmodule : fbmb_mailbox

`default_nettype wire

// File: core/fbmb_pkg.sv
`default_nettype none

package fbmb_pkg;

	// ************************************************************
	// Geometry of the dual-port slot memory.
	// ************************************************************
	localparam int SLOTS = 16;
	localparam int SLOT_BYTES = 20;
	localparam logic [8:0] SLOT_STRIDE = 9'h014;
	localparam logic [8:0] MEM_BYTES = 9'h140;

	// ************************************************************
	// General instrument layout, byte offsets within a slot.
	// ************************************************************
	localparam logic [4:0] OFF_CMD = 5'h00;
	localparam logic [4:0] OFF_CNT = 5'h01;
	localparam logic [4:0] OFF_ADR = 5'h02;
	localparam logic [4:0] OFF_WREG = 5'h04;
	localparam logic [4:0] OFF_ERR = 5'h01;
	localparam logic [4:0] OFF_WGT = 5'h02;
	localparam logic [4:0] OFF_ST1 = 5'h08;
	localparam logic [4:0] OFF_ST2_LO = 5'h0B;
	localparam logic [4:0] OFF_WIN = 5'h0C;
	localparam logic [4:0] OFF_RREG = 5'h0E;

	// ************************************************************
	// Weighing-transmitter layout, byte offsets within a slot.
	// ************************************************************
	localparam logic [4:0] OFF_WCMD = 5'h0A;
	localparam logic [4:0] OFF_SP = 5'h0C;
	localparam logic [4:0] OFF_WSTAT = 5'h02;
	localparam logic [4:0] OFF_GROSS = 5'h04;
	localparam logic [4:0] OFF_NET = 5'h08;

	// ************************************************************
	// Command and answer codes.
	// ************************************************************
	localparam logic [7:0] CODE_WRITE = 8'hC8;
	localparam logic [7:0] CODE_WINDOW = 8'hC9;
	localparam logic [7:0] CODE_PF_CLEAR = 8'hCA;
	localparam logic [7:0] ERR_COMM = 8'hFF;
	localparam logic [7:0] MAX_REGS = 8'h08;
	localparam logic [3:0] WINDOW_REGS = 4'h3;
	localparam int PF_BIT = 4;
	localparam logic [15:0] WCMD_LAST = 16'h000C;

	typedef enum logic [3:0] {
		act_none,
		act_relay1_on,
		act_relay1_off,
		act_relay2_on,
		act_relay2_off,
		act_both_on,
		act_both_off,
		act_auto_tare,
		act_set_zero,
		act_gross_mode,
		act_net_mode,
		act_normal_weight,
		act_cal_value
	} fbmb_act_t;

endpackage : fbmb_pkg

`default_nettype wire

// File: core/fbmb_wei_decode.sv
`default_nettype none

module fbmb_wei_decode (
	input wire logic [15:0] cmd_word,
	output fbmb_pkg::fbmb_act_t act
);

	always_comb begin
		unique case (cmd_word)
			16'h0001: act = fbmb_pkg::act_relay1_on;
			16'h0002: act = fbmb_pkg::act_relay1_off;
			16'h0003: act = fbmb_pkg::act_relay2_on;
			16'h0004: act = fbmb_pkg::act_relay2_off;
			16'h0005: act = fbmb_pkg::act_both_on;
			16'h0006: act = fbmb_pkg::act_both_off;
			16'h0007: act = fbmb_pkg::act_auto_tare;
			16'h0008: act = fbmb_pkg::act_set_zero;
			16'h0009: act = fbmb_pkg::act_gross_mode;
			16'h000A: act = fbmb_pkg::act_net_mode;
			16'h000B: act = fbmb_pkg::act_normal_weight;
			16'h000C: act = fbmb_pkg::act_cal_value;
			// Zero and every value above the table do nothing.
			default: act = fbmb_pkg::act_none;
		endcase
	end

endmodule : fbmb_wei_decode

`default_nettype wire

// File: testbench/fbmb_serial_model.sv
`default_nettype none

module fbmb_serial_model (
	input wire logic clk,
	input wire logic srst,
	input wire logic cmd_valid,
	input wire logic [3:0] cmd_slot,
	input wire logic [7:0] cmd_code,
	input wire logic poll,
	input wire logic [3:0] poll_slot,
	input wire logic fail,
	input wire logic [7:0] dly,
	input wire logic [231:0] pay,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [3:0] rsp_slot,
	output logic rsp_fail,
	output logic [7:0] rsp_ack,
	output logic [231:0] rsp_pay
);
	timeunit 1ns;
	timeprecision 1ns;
	logic busy_q;
	logic [7:0] wait_q;
	// Unqualified payload and fail outputs show the complement, so a stale sample cannot pass.
	assign rsp_pay = rsp_valid ? pay : ~pay;
	assign rsp_fail = rsp_valid ? fail : !fail;
	// Ready drops with the command itself, so the scanner cannot slip a second
	// command past in the cycle before busy is registered.
	assign cmd_ready = !busy_q && !cmd_valid;
	always_ff @(posedge clk) begin
		rsp_valid <= 1'b0;
		if (srst) begin
			busy_q <= 1'b0;
			wait_q <= 8'h00;
		end else if (cmd_valid) begin
			busy_q <= 1'b1;
			wait_q <= dly;
			rsp_slot <= cmd_slot;
			rsp_ack <= cmd_code;
		end else if (busy_q && wait_q == 8'h00) begin
			busy_q <= 1'b0;
			rsp_valid <= 1'b1;
		end else if (busy_q) begin
			wait_q <= wait_q - 8'h01;
		end else if (poll) begin
			rsp_valid <= 1'b1;
			rsp_slot <= poll_slot;
		end
	end
endmodule : fbmb_serial_model

`default_nettype wire

// File: testbench/test_fieldbus_slave_mailbox_map.sv
`default_nettype none

module test_fieldbus_slave_mailbox_map;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [8:0] bus_addr = 9'h000;
	logic [7:0] bus_wdata = 8'h00;
	logic bus_we = 1'b0;
	logic bus_re = 1'b0;
	logic [7:0] bus_rdata;
	logic [15:0] slot_is_wei = 16'h8000;
	logic cmd_ready, cmd_valid, act_valid, rsp_valid, rsp_fail;
	logic [3:0] cmd_slot, cmd_count, act_slot, rsp_slot;
	logic [7:0] cmd_code, rsp_ack;
	logic [15:0] cmd_addr;
	logic [127:0] cmd_data;
	fbmb_pkg::fbmb_act_t act_code;
	logic [231:0] rsp_pay;
	logic [255:0] pay = '0;
	logic poll = 1'b0;
	logic fail = 1'b0;
	logic [7:0] dly = 8'h05;
	logic [31:0] rng = 32'h00000020;
	logic [7:0] exp_tx [0:319];
	logic [7:0] mst [0:319];
	logic [15:0] win [0:15];
	int errors = 0;
	int cmp_count = 0;
	int cyc = 0;

	fbmb_mailbox dut_u (
		.clk, .srst, .bus_addr, .bus_wdata, .bus_we, .bus_re, .bus_rdata, .slot_is_wei,
		.cmd_ready, .cmd_valid, .cmd_slot, .cmd_code, .cmd_count, .cmd_addr, .cmd_data,
		.act_valid, .act_slot, .act_code, .rsp_valid, .rsp_slot, .rsp_fail, .rsp_ack,
		.rsp_err(rsp_pay[231:224]), .rsp_weight(rsp_pay[223:176]), .rsp_stat1(rsp_pay[175:160]),
		.rsp_stat2(rsp_pay[159:144]), .rsp_regs(rsp_pay[143:96]), .rsp_werr(rsp_pay[95:80]),
		.rsp_wstat(rsp_pay[79:64]), .rsp_gross(rsp_pay[63:32]), .rsp_net(rsp_pay[31:0])
	);
	fbmb_serial_model serial_u (
		.clk, .srst, .cmd_valid, .cmd_slot, .cmd_code, .poll, .poll_slot(4'hF), .fail, .dly,
		.pay(pay[231:0]), .cmd_ready, .rsp_valid, .rsp_slot, .rsp_fail, .rsp_ack, .rsp_pay
	);

	always #5 clk = ~clk;

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			errors = errors + 1;
			close_out();
		end
	end

	// ************************************************************
	// Bus cycles, model and comparison.
	// ************************************************************
	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : xs

	task automatic chk(input logic [191:0] got, input logic [191:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input int a, input logic [7:0] d);
		@(posedge clk);
		bus_we <= 1'b1;
		bus_addr <= a[8:0];
		bus_wdata <= d;
		if (a < 320) mst[a] = d;
		@(posedge clk);
		bus_we <= 1'b0;
	endtask : wr

	task automatic rd(input int a, output logic [7:0] d);
		@(posedge clk);
		bus_re <= 1'b1;
		bus_addr <= a[8:0];
		@(posedge clk);
		bus_re <= 1'b0;
		#1 d = bus_rdata;
	endtask : rd

	task automatic wait_for(input int which, input int lim, output bit seen);
		seen = 1'b0;
		for (int i = 0; i < lim && !seen; i++) begin
			#1;
			seen = which == 0 ? cmd_valid === 1'b1 : which == 1 ? act_valid === 1'b1
				: rsp_valid === 1'b1;
			if (!seen) @(posedge clk);
		end
	endtask : wait_for

	function automatic logic [127:0] data_of(input int s);
		logic [127:0] r;
		for (int b = 0; b < 16; b++) r[127 - 8 * b -: 8] = mst[s * 20 + 4 + b];
		return r;
	endfunction : data_of

	// Works out the returned slot from the answer payload, as the serial side delivered it.
	task automatic expect_slot(input int s, input logic [7:0] ack);
		logic [159:0] v;
		logic w;
		w = slot_is_wei[s[3:0]];
		v = w ? {fail ? 16'hFFFF : pay[95:80], pay[79:0], 64'h0}
			: {fail ? 16'hFFFF : {ack, pay[231:224]}, pay[223:144], win[s], pay[143:96]};
		if (ack == fbmb_pkg::CODE_PF_CLEAR && !fail && !w) v[68] = 1'b0;
		for (int b = 0; b < 20; b++) begin
			exp_tx[s * 20 + b] = (w && b > 11) ? mst[s * 20 + b] : v[159 - 8 * b -: 8];
		end
	endtask : expect_slot

	task automatic chk_slot(input int s, input int n);
		logic [7:0] d;
		for (int b = 0; b < n; b++) begin
			rd(s * 20 + b, d);
			chk(d, exp_tx[s * 20 + b]);
		end
	endtask : chk_slot

	task automatic gen_cmd(input int s, input logic [7:0] code, input logic [3:0] n_reg, input int n);
		bit seen;
		wr(s * 20, code);
		wait_for(0, 40, seen);
		chk({seen, cmd_slot, cmd_code, cmd_count, cmd_addr, cmd_data},
			{1'b1, s[3:0], code, n_reg, mst[s * 20 + 2], mst[s * 20 + 3], data_of(s)});
		wait_for(2, 80, seen);
		chk(seen, 1'b1);
		expect_slot(s, code);
		repeat (3) @(posedge clk);
		chk_slot(s, n);
	endtask : gen_cmd

	task automatic close_out();
		$display("errors=%0d comparisons=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out

	initial begin
		logic [7:0] d;
		logic [15:0] w;
		logic [15:0] last;
		bit seen;
		for (int i = 0; i < 320; i++) begin
			exp_tx[i] = 8'h00;
			mst[i] = 8'h00;
		end
		for (int i = 0; i < 16; i++) win[i] = 16'h0000;
		for (int i = 0; i < 8; i++) pay[i * 32 +: 32] = xs();
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		wr(21, 8'h08);
		for (int b = 2; b < 20; b++) wr(20 + b, pay[8 * b +: 8]);
		gen_cmd(1, fbmb_pkg::CODE_WRITE, 4'h8, 20);
		dly <= 8'h28;
		wr(41, 8'h05);
		wr(42, 8'h9C);
		wr(43, 8'h5F);
		win[2] = 16'h9C5F;
		gen_cmd(2, fbmb_pkg::CODE_WINDOW, 4'h3, 20);
		wr(40, fbmb_pkg::CODE_WINDOW);
		wait_for(0, 40, seen);
		chk(seen, 1'b0);
		pay[148] <= 1'b1;
		gen_cmd(2, fbmb_pkg::CODE_PF_CLEAR, 4'h5, 20);
		fail <= 1'b1;
		dly <= 8'h01;
		wr(81, 8'h0C);
		gen_cmd(4, fbmb_pkg::CODE_WRITE, 4'h8, 2);
		fail <= 1'b0;
		for (int b = 12; b < 20; b++) wr(300 + b, pay[8 * b +: 8]);
		last = 16'h0000;
		for (int k = 1; k < 17; k++) begin
			w = k < 14 ? k[15:0] : (k < 16 ? 16'h000C : 16'hFFFF);
			wr(310, w[15:8]);
			wr(311, w[7:0]);
			wait_for(1, 40, seen);
			chk({seen, act_slot}, {w != last && w >= 1 && w <= 12, 4'hF});
			if (seen) chk(act_code, w[3:0]);
			last = w;
		end
		@(posedge clk);
		poll <= 1'b1;
		@(posedge clk);
		poll <= 1'b0;
		wait_for(2, 20, seen);
		chk(seen, 1'b1);
		expect_slot(15, 8'h00);
		repeat (20) @(posedge clk);
		chk_slot(15, 20);
		wr(320, 8'hA5);
		rd(320, d);
		chk(d, 8'h00);
		close_out();
	end
endmodule : test_fieldbus_slave_mailbox_map

`default_nettype wire
